//--- hw/pmc_ctrl_regs.sv
// Serial control registers 0 and 1 with derived driver and regulator enables
`timescale 1ns/1ps

module pmc_ctrl_regs (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  spi_clk,
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_mosi,
    output logic                       spi_miso,
    output logic                       spi_miso_oe,
    input  wire logic [21:0]           status_reg0,
    input  wire logic [21:0]           status_reg1,
    input  wire logic                  status_error,
    input  wire pmc_pkg::pmc_op_mode_t op_mode,
    input  wire logic                  timer1_on,
    input  wire logic                  timer2_on,
    input  wire logic                  pwm_input_one,
    input  wire logic                  pwm_input_two,
    output logic [3:0]                 small_highside_on,
    output logic                       main_highside_on,
    output logic [1:0]                 relay_on,
    output logic                       second_regulator_on,
    output logic                       watchdog_trigger,
    output logic                       enter_core_standby,
    output logic                       enter_battery_standby,
    output logic [3:0]                 wake_input_enable,
    output logic [3:0]                 open_load_wake_enable,
    output logic                       interrupt_enable,
    output logic                       clear_status,
    output logic [11:0]                timer1_period_ms,
    output logic [4:0]                 timer1_on_ms,
    output logic [5:0]                 timer2_period_ms,
    output logic [9:0]                 timer2_on_us
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] spi_sync;
    logic [1:0] pwm_sync;

    pmc_sync #(
        .WIDTH       (3),
        .RESET_VALUE (3'h1)
    ) u_spi_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({spi_mosi, spi_clk, spi_cs_n}),
        .sync_out (spi_sync)
    );

    pmc_sync #(
        .WIDTH       (2),
        .RESET_VALUE (2'h0)
    ) u_pwm_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({pwm_input_two, pwm_input_one}),
        .sync_out (pwm_sync)
    );

    // ------------------------------------------------------------------
    // Frame decoding
    // ------------------------------------------------------------------
    logic        sck_q;
    logic        cs_n_q;
    logic [4:0]  bit_cnt;
    logic [23:0] shift_in;
    logic [21:0] shift_out;
    logic [21:0] ctrl0;
    logic [21:0] ctrl1;

    wire         cs_n_s      = spi_sync[0];
    wire         sck_s       = spi_sync[1];
    wire         mosi_s      = spi_sync[2];
    wire         in_frame    = ~cs_n_s;
    wire         sck_rise    = in_frame & sck_s & ~sck_q;
    wire         sck_fall    = in_frame & ~sck_s & sck_q;
    wire         frame_start = cs_n_q & ~cs_n_s;
    wire         frame_end   = ~cs_n_q & cs_n_s;
    wire [4:0]   cnt_inc     = (bit_cnt > pmc_pkg::FRAME_BITS) ? bit_cnt : bit_cnt + 5'h01;
    wire [23:0]  next_shift  = {shift_in[22:0], mosi_s};
    wire [1:0]   addr_now    = {shift_in[0], mosi_s};
    wire         addr_done   = sck_rise & (bit_cnt == 5'h01);
    wire [21:0]  status_sel  = (addr_now == pmc_pkg::ADDR_CTRL1) ? status_reg1 : status_reg0;
    wire         out_step    = sck_fall & (bit_cnt >= 5'h02) & (bit_cnt < pmc_pkg::FRAME_BITS);
    wire         frame_ok    = frame_end & (bit_cnt == pmc_pkg::FRAME_BITS);
    wire [1:0]   frame_addr  = shift_in[23:22];
    wire [21:0]  frame_data  = shift_in[21:0];
    wire         wr_ctrl0    = frame_ok & (frame_addr == pmc_pkg::ADDR_CTRL0);
    wire         wr_ctrl1    = frame_ok & (frame_addr == pmc_pkg::ADDR_CTRL1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            bit_cnt  <= 5'h00;
            shift_in <= 24'h000000;
        end else begin
            sck_q  <= sck_s;
            cs_n_q <= cs_n_s;
            if (frame_start) begin
                bit_cnt <= 5'h00;
            end else if (sck_rise) begin
                bit_cnt  <= cnt_inc;
                shift_in <= next_shift;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial output: error flag during address, then the status word
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
            shift_out   <= 22'h000000;
        end else begin
            spi_miso_oe <= in_frame;
            if (frame_start) begin
                spi_miso <= status_error;
            end else if (addr_done) begin
                shift_out <= status_sel;
            end else if (out_step) begin
                spi_miso  <= shift_out[21];
                shift_out <= {shift_out[20:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers and write side effects
    // ------------------------------------------------------------------
    wire wd_changed = frame_data[pmc_pkg::WD_TOGGLE_BIT] != ctrl0[pmc_pkg::WD_TOGGLE_BIT];
    wire go_bat     = frame_data[pmc_pkg::GO_BAT_BIT];
    wire go_core    = frame_data[pmc_pkg::GO_CORE_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl0                 <= pmc_pkg::CTRL0_RESET;
            ctrl1                 <= pmc_pkg::CTRL1_RESET;
            watchdog_trigger      <= 1'b0;
            enter_core_standby    <= 1'b0;
            enter_battery_standby <= 1'b0;
            clear_status          <= 1'b0;
        end else begin
            if (wr_ctrl0) begin
                ctrl0 <= frame_data;
            end
            if (wr_ctrl1) begin
                ctrl1 <= frame_data;
            end
            watchdog_trigger      <= wr_ctrl0 & wd_changed;
            enter_battery_standby <= wr_ctrl0 & go_bat;
            enter_core_standby    <= wr_ctrl0 & go_core & ~go_bat;
            clear_status          <= wr_ctrl1 & frame_data[pmc_pkg::CLEAR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Driver and regulator decode
    // ------------------------------------------------------------------
    function automatic logic hs_drive(
        input logic [2:0] code,
        input logic       active,
        input logic       t1,
        input logic       t2,
        input logic       p1,
        input logic       p2
    );
        logic on;
        on = 1'b0;
        case (code)
            pmc_pkg::HS_ACTIVE: on = active;
            pmc_pkg::HS_TIMER1: on = t1;
            pmc_pkg::HS_TIMER2: on = t2;
            pmc_pkg::HS_PWM_INPUT_ONE:   on = p1;
            pmc_pkg::HS_PWM_INPUT_TWO:   on = p2;
            default:            on = 1'b0;
        endcase
        return on;
    endfunction : hs_drive

    wire       mode_active = (op_mode == pmc_pkg::PMC_MODE_ACTIVE);
    wire       mode_bat    = (op_mode == pmc_pkg::PMC_MODE_BAT_STBY);
    wire [1:0] v2_mode     = ctrl0[pmc_pkg::V2_MODE_LSB +: 2];
    wire [1:0] relay_bits  = ctrl0[pmc_pkg::RELAY_LSB +: 2];
    wire [2:0] t1_period   = ctrl1[pmc_pkg::T1_PERIOD_LSB +: 3];

    logic [3:0] next_small_hs_on;
    wire        next_main_hs_on = hs_drive(ctrl0[pmc_pkg::MAIN_HS_LSB +: 3], mode_active,
                                           timer1_on, timer2_on, pwm_sync[0], pwm_sync[1]);
    wire        next_v2_on      = (v2_mode == pmc_pkg::V2_ALWAYS) |
                                  ((v2_mode == pmc_pkg::V2_NOT_BAT) & ~mode_bat) |
                                  ((v2_mode == pmc_pkg::V2_ACTIVE) & mode_active);
    wire [11:0] next_t1_period  = 12'(({9'h000, t1_period} + 12'h001)
                                      * pmc_pkg::TIMER1_STEP_MS);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_small_hs
            assign next_small_hs_on[gi] = hs_drive(ctrl0[pmc_pkg::SMALL_HS_LSB + 3 * gi +: 3],
                                                   mode_active, timer1_on, timer2_on,
                                                   pwm_sync[0], pwm_sync[1]);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            small_highside_on   <= 4'h0;
            main_highside_on    <= 1'b0;
            relay_on            <= 2'h0;
            second_regulator_on <= 1'b0;
        end else begin
            small_highside_on   <= next_small_hs_on;
            main_highside_on    <= next_main_hs_on;
            relay_on            <= relay_bits & {2{mode_active}};
            second_regulator_on <= next_v2_on;
        end
    end

    // ------------------------------------------------------------------
    // Wake, interrupt and cyclic timer configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_input_enable     <= ~pmc_pkg::CTRL1_RESET[pmc_pkg::WAKE_IN_LSB +: 4];
            open_load_wake_enable <= ~pmc_pkg::CTRL1_RESET[pmc_pkg::WAKE_OL_LSB +: 4];
            interrupt_enable      <= 1'b0;
            timer1_period_ms      <= pmc_pkg::TIMER1_STEP_MS;
            timer1_on_ms          <= pmc_pkg::TIMER1_ON_SHORT_MS;
            timer2_period_ms      <= pmc_pkg::TIMER2_PERIOD_MS;
            timer2_on_us          <= pmc_pkg::TIMER2_ON_SHORT_US;
        end else begin
            wake_input_enable     <= ~ctrl1[pmc_pkg::WAKE_IN_LSB +: 4];
            open_load_wake_enable <= ~ctrl1[pmc_pkg::WAKE_OL_LSB +: 4];
            interrupt_enable      <= ctrl1[pmc_pkg::INT_EN_BIT];
            timer1_period_ms      <= next_t1_period;
            timer1_on_ms          <= ctrl1[pmc_pkg::T1_ON_BIT] ? pmc_pkg::TIMER1_ON_LONG_MS
                                                               : pmc_pkg::TIMER1_ON_SHORT_MS;
            timer2_period_ms      <= pmc_pkg::TIMER2_PERIOD_MS;
            timer2_on_us          <= ctrl1[pmc_pkg::T2_ON_BIT] ? pmc_pkg::TIMER2_ON_LONG_US
                                                               : pmc_pkg::TIMER2_ON_SHORT_US;
        end
    end

endmodule : pmc_ctrl_regs

//--- hw/pmc_pkg.sv
// Constants shared by the serial control register block
package pmc_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS   = 5'h18;
    localparam int         DATA_BITS    = 22;
    localparam logic [1:0] ADDR_CTRL0   = 2'h0;
    localparam logic [1:0] ADDR_CTRL1   = 2'h1;

    // ------------------------------------------------------------------
    // Register resets
    // ------------------------------------------------------------------
    localparam logic [21:0] CTRL0_RESET = 22'h000000;
    localparam logic [21:0] CTRL1_RESET = 22'h000000;

    // ------------------------------------------------------------------
    // Driver and regulator mode, watchdog toggle and standby request register fields
    // ------------------------------------------------------------------
    localparam int SMALL_HS_LSB   = 0;
    localparam int MAIN_HS_LSB    = 12;
    localparam int RELAY_LSB      = 15;
    localparam int V2_MODE_LSB    = 17;
    localparam int WD_TOGGLE_BIT  = 19;
    localparam int GO_BAT_BIT     = 20;
    localparam int GO_CORE_BIT    = 21;

    // ------------------------------------------------------------------
    // Wake, timer, interrupt enable and status clear register fields
    // ------------------------------------------------------------------
    localparam int WAKE_IN_LSB    = 0;
    localparam int WAKE_OL_LSB    = 4;
    localparam int T1_PERIOD_LSB  = 15;
    localparam int T1_ON_BIT      = 18;
    localparam int T2_ON_BIT      = 19;
    localparam int INT_EN_BIT     = 20;
    localparam int CLEAR_BIT      = 21;

    // ------------------------------------------------------------------
    // High-side driver mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] HS_OFF     = 3'h0;
    localparam logic [2:0] HS_ACTIVE  = 3'h1;
    localparam logic [2:0] HS_TIMER1  = 3'h2;
    localparam logic [2:0] HS_TIMER2  = 3'h3;
    localparam logic [2:0] HS_PWM_INPUT_ONE    = 3'h4;
    localparam logic [2:0] HS_PWM_INPUT_TWO    = 3'h5;

    // ------------------------------------------------------------------
    // Second regulator mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] V2_OFF      = 2'h0;
    localparam logic [1:0] V2_ACTIVE   = 2'h1;
    localparam logic [1:0] V2_NOT_BAT  = 2'h2;
    localparam logic [1:0] V2_ALWAYS   = 2'h3;

    // ------------------------------------------------------------------
    // Cyclic timer timing
    // ------------------------------------------------------------------
    localparam logic [11:0] TIMER1_STEP_MS     = 12'h1F4;
    localparam logic [4:0]  TIMER1_ON_SHORT_MS = 5'h0A;
    localparam logic [4:0]  TIMER1_ON_LONG_MS  = 5'h14;
    localparam logic [5:0]  TIMER2_PERIOD_MS   = 6'h32;
    localparam logic [9:0]  TIMER2_ON_SHORT_US = 10'h064;
    localparam logic [9:0]  TIMER2_ON_LONG_US  = 10'h3E8;

    // ------------------------------------------------------------------
    // Operating mode of the device
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMC_MODE_ACTIVE,
        PMC_MODE_CORE_STBY,
        PMC_MODE_BAT_STBY
    } pmc_op_mode_t;

endpackage : pmc_pkg

//--- hw/pmc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pmc_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pmc_sync needs WIDTH of at least one");
        end
    endgenerate

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Output follows only where the second and third stage agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= RESET_VALUE;
            stage2   <= RESET_VALUE;
            stage3   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
        end
    end

endmodule : pmc_sync

//--- sim/pmc_ctrl_regs_monitor.sv
// Concurrent checks on the outputs of the control register block
`timescale 1ns/1ps
module pmc_ctrl_regs_monitor (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic                  spi_cs_n,
    input wire pmc_pkg::pmc_op_mode_t op_mode,
    input wire logic                  timer1_on,
    input wire logic                  timer2_on,
    input wire logic                  pwm_input_one,
    input wire logic                  pwm_input_two,
    input wire logic [3:0]            small_highside_on,
    input wire logic                  main_highside_on,
    input wire logic [1:0]            relay_on,
    input wire logic                  watchdog_trigger,
    input wire logic                  enter_core_standby,
    input wire logic                  enter_battery_standby,
    input wire logic [3:0]            wake_input_enable,
    input wire logic                  interrupt_enable,
    input wire logic                  clear_status,
    input wire logic [11:0]           timer1_period_ms,
    input wire logic [4:0]            timer1_on_ms,
    input wire logic [5:0]            timer2_period_ms,
    input wire logic [9:0]            timer2_on_us
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------------
    // Assertions and cover points
    // ------------------------------------------------------------------
    a_wd_single_pulse: assert property (watchdog_trigger |-> spi_cs_n
        ##1 !watchdog_trigger)
        else $error("watchdog trigger is not a single pulse after a frame");
    a_bat_stby_wins: assert property (enter_battery_standby |-> !enter_core_standby
        && spi_cs_n ##1 !enter_battery_standby)
        else $error("battery standby pulse overlaps core standby or lasts");
    a_clear_pulse: assert property (clear_status |-> spi_cs_n ##1 !clear_status)
        else $error("clear pulse is not single or came inside a frame");
    a_frame_stable: assert property (!spi_cs_n [*8] |=> $stable(wake_input_enable)
        && $stable(interrupt_enable) && $stable(timer1_period_ms))
        else $error("configuration changed while a frame was open");
    a_relay_stby_off: assert property (op_mode != pmc_pkg::PMC_MODE_ACTIVE
        |=> relay_on == 2'h0)
        else $error("relay driven outside active mode");
    a_hs_stby_off: assert property ((!pwm_input_one && !pwm_input_two) [*6] ##0
        (op_mode != pmc_pkg::PMC_MODE_ACTIVE && !timer1_on && !timer2_on)
        |=> !main_highside_on && small_highside_on == 4'h0)
        else $error("high-side driver on in standby with no timer or pwm source");
    a_t2_fixed: assert property (timer2_period_ms == 6'h32
        && timer2_on_us inside {10'h064, 10'h3E8})
        else $error("timer 2 timing outside its two settings");
    a_t1_range: assert property (timer1_period_ms inside {[12'h1F4:12'hFA0]}
        && timer1_period_ms % 12'h1F4 == 12'h000 && timer1_on_ms inside {5'h0A, 5'h14})
        else $error("timer 1 timing outside its settings");
    c_wd: cover property (watchdog_trigger);
    c_core: cover property (enter_core_standby);
    c_bat: cover property (enter_battery_standby);
    c_clear: cover property (clear_status);
endmodule : pmc_ctrl_regs_monitor

//--- sim/pmc_ctrl_regs_host.sv
// Serial host model that sends frames and collects the shifted-out status
`timescale 1ns/1ps
module pmc_ctrl_regs_host (
    input  wire logic clk,
    input  wire logic spi_miso,
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    localparam int HALF = 8;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Frames of fewer than 24 bits model an aborted transfer
    task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge clk);
        spi_cs_n = 1'b0;
        repeat (HALF) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            spi_mosi = tx[23-i];
            repeat (HALF) @(negedge clk);
            spi_clk = 1'b1;
            rx = {rx[22:0], spi_miso};
            repeat (HALF) @(negedge clk);
            spi_clk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        spi_cs_n = 1'b1;
        // Released data line must not keep looking valid
        spi_mosi = ~spi_mosi;
        repeat (HALF) @(negedge clk);
    endtask : frame
endmodule : pmc_ctrl_regs_host

//--- sim/pmc_ctrl_regs_tb.sv
// Self-checking bench for the serial control register block
`timescale 1ns/1ps
bind pmc_ctrl_regs pmc_ctrl_regs_monitor pmc_ctrl_regs_monitor_inst (
    .clk(clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .op_mode(op_mode),
    .timer1_on(timer1_on), .timer2_on(timer2_on), .pwm_input_one(pwm_input_one),
    .pwm_input_two(pwm_input_two), .small_highside_on(small_highside_on),
    .main_highside_on(main_highside_on), .relay_on(relay_on),
    .watchdog_trigger(watchdog_trigger), .enter_core_standby(enter_core_standby),
    .enter_battery_standby(enter_battery_standby), .wake_input_enable(wake_input_enable),
    .interrupt_enable(interrupt_enable), .clear_status(clear_status),
    .timer1_period_ms(timer1_period_ms), .timer1_on_ms(timer1_on_ms),
    .timer2_period_ms(timer2_period_ms), .timer2_on_us(timer2_on_us));
module pmc_ctrl_regs_tb;
    logic                  clk = 1'b0, reset_n = 1'b0, status_error = 1'b0;
    logic                  timer1_on = 1'b0, timer2_on = 1'b0;
    logic                  pwm_input_one = 1'b0, pwm_input_two = 1'b0;
    logic [21:0]           status_reg0 = 22'h0, status_reg1 = 22'h0, d;
    pmc_pkg::pmc_op_mode_t op_mode = pmc_pkg::PMC_MODE_ACTIVE;
    logic                  spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, wd;
    logic [3:0]            small_highside_on, wake_input_enable, open_load_wake_enable;
    logic                  main_highside_on, second_regulator_on, watchdog_trigger;
    logic                  enter_core_standby, enter_battery_standby;
    logic                  interrupt_enable, clear_status;
    logic [1:0]            relay_on;
    logic [11:0]           timer1_period_ms;
    logic [4:0]            timer1_on_ms;
    logic [5:0]            timer2_period_ms;
    logic [9:0]            timer2_on_us;
    logic [23:0]           rx;
    logic [31:0]           seed = 32'h6, r;
    int                    failures = 0, n_tests = 0, n_wd, n_core, n_bat, n_clr, n_oe;
    always #25 clk = ~clk;
    pmc_ctrl_regs_host host_inst (.clk(clk), .spi_miso(spi_miso), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
    pmc_ctrl_regs pmc_ctrl_regs_inst (.clk(clk), .reset_n(reset_n), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .status_reg0(status_reg0), .status_reg1(status_reg1),
        .status_error(status_error), .op_mode(op_mode), .timer1_on(timer1_on),
        .timer2_on(timer2_on), .pwm_input_one(pwm_input_one), .pwm_input_two(pwm_input_two),
        .small_highside_on(small_highside_on), .main_highside_on(main_highside_on),
        .relay_on(relay_on), .second_regulator_on(second_regulator_on),
        .watchdog_trigger(watchdog_trigger), .enter_core_standby(enter_core_standby),
        .enter_battery_standby(enter_battery_standby), .wake_input_enable(wake_input_enable),
        .open_load_wake_enable(open_load_wake_enable), .interrupt_enable(interrupt_enable),
        .clear_status(clear_status), .timer1_period_ms(timer1_period_ms),
        .timer1_on_ms(timer1_on_ms), .timer2_period_ms(timer2_period_ms),
        .timer2_on_us(timer2_on_us));
    always @(posedge clk) begin
        if (watchdog_trigger === 1'b1) n_wd++;
        if (enter_core_standby === 1'b1) n_core++;
        if (enter_battery_standby === 1'b1) n_bat++;
        if (clear_status === 1'b1) n_clr++;
        if (spi_miso_oe === 1'b1) n_oe++;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic hs_exp(input logic [2:0] c, input logic act, input logic [3:0] s);
        case (c)
            3'h1: return act;
            3'h2: return s[0];
            3'h3: return s[1];
            3'h4: return s[2];
            3'h5: return s[3];
            default: return 1'b0;
        endcase
    endfunction : hs_exp
    function automatic logic v2_exp(input logic [1:0] c, input int m);
        case (c)
            2'h0: return 1'b0;
            2'h1: return m == 0;
            2'h2: return m != 2;
            default: return 1'b1;
        endcase
    endfunction : v2_exp
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic chk_cnt(input string nm, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_cnt
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [1:0] a, input logic [21:0] v, input int nb);
        n_wd = 0; n_core = 0; n_bat = 0; n_clr = 0; n_oe = 0;
        host_inst.frame({a, v}, nb, rx);
        repeat (4) @(negedge clk);
        chk_cnt("miso_oe", 2 * host_inst.HALF * (nb + 1), n_oe);
    endtask : wr
    task automatic chk_out(input logic [21:0] c);
        logic [3:0] e;
        logic       act;
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 3; k++) begin
                r = xs();
                op_mode = pmc_pkg::pmc_op_mode_t'(m);
                {pwm_input_two, pwm_input_one, timer2_on, timer1_on} = r[3:0];
                repeat (8) @(negedge clk);
                act = (m == 0);
                for (int j = 0; j < 4; j++) e[j] = hs_exp(c[3*j +: 3], act, r[3:0]);
                chk("small_hs", {20'h0, e}, 24'(small_highside_on));
                chk("main_hs", {23'h0, hs_exp(c[14:12], act, r[3:0])},
                    24'(main_highside_on));
                chk("relay", {22'h0, c[16:15] & {2{act}}}, 24'(relay_on));
                chk("v2", {23'h0, v2_exp(c[18:17], m)}, 24'(second_regulator_on));
            end
        end
        op_mode = pmc_pkg::PMC_MODE_ACTIVE;
    endtask : chk_out
    task automatic chk_c1(input logic [21:0] c);
        chk("wake_in", {20'h0, ~c[3:0]}, 24'(wake_input_enable));
        chk("wake_ol", {20'h0, ~c[7:4]}, 24'(open_load_wake_enable));
        chk("int_en", {23'h0, c[20]}, 24'(interrupt_enable));
        chk("t1_per", 24'((int'(c[17:15]) + 1) * 500), 24'(timer1_period_ms));
        chk("t1_on", c[18] ? 24'h14 : 24'h0A, 24'(timer1_on_ms));
        chk("t2_on", c[19] ? 24'h3E8 : 24'h064, 24'(timer2_on_us));
        chk("t2_per", 24'h32, 24'(timer2_period_ms));
    endtask : chk_c1
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
        chk_c1(22'h0);
        $display("test reset done");
        wd = 1'b0;
        for (int i = 0; i < 10; i++) begin
            r = xs();
            wd = ~wd;
            d = {2'h0, wd, r[18:15], 3'(i), r[11:0]};
            {status_reg0, status_error} = {r[31:10], r[9]};
            status_reg1 = ~r[21:0];
            wr(2'h0, d, 24);
            chk("rx0", {{2{status_error}}, status_reg0}, rx);
            chk_cnt("wd", 1, n_wd);
            chk_out(d);
        end
        wr(2'h0, d, 24);
        chk_cnt("wd_same", 0, n_wd);
        for (int s = 1; s < 4; s++) begin
            wr(2'h0, {2'(s), d[19:0]}, 24);
            chk_cnt("core", int'(s == 2), n_core);
            chk_cnt("bat", int'(s != 2), n_bat);
        end
        wr(2'h0, {2'h3, ~d[19:0]}, 23);
        chk_cnt("abort_pulses", 0, n_wd + n_core + n_bat);
        $display("test ctrl0 done");
        for (int i = 0; i < 8; i++) begin
            r = xs();
            d = r[21:0];
            d[17:15] = 3'(i);
            d[21] = i[0];
            if (i == 2) d[7:0] = 8'h00;
            {status_reg1, status_error} = {r[31:10], r[8]};
            wr(2'h1, d, 24);
            chk("rx1", {{2{status_error}}, status_reg1}, rx);
            chk_c1(d);
            chk_cnt("clr", int'(d[21]), n_clr);
        end
        wr(2'h1, {1'b1, ~d[20:0]}, 23);
        chk_c1(d);
        chk_cnt("clr_abort", 0, n_clr);
        $display("test ctrl1 done");
        conclude();
    end
endmodule : pmc_ctrl_regs_tb
